// *** bench/tb_trw_gen.sv ***
// Self-checking bench of the ramp wave generator
`timescale 1ns/100ps
`include "trw_defs.vh"
module tb_trw_gen;
   logic        mclk_in;
   logic        rst_n_in;
   logic        err_clr_in;
   logic        dev_err_in;
   logic [6:0]  volt_static_in;
   logic [6:0]  curr_static_in;
   wire  [6:0]  stb;
   wire  [32:0] val;
   wire  [6:0]  volt_set_out;
   wire  [6:0]  curr_set_out;
   wire  [1:0]  sel_out;
   wire  [1:0]  seg_out;
   wire  [2:0]  idx_out;
   wire         running_out;
   wire         cfg_done_out;
   wire         err_out;
   int          n_errors = 0;
   int          total_checks = 0;
   int          lo;
   int          hi;
   int          i;
   int          t[4];
   int          bad_i[5] = '{2, 0, 0, 4, 0};
   int          bad_k[5] = '{2, 2, 3, 3, 3};
   logic [32:0] bad_v[5] = '{50, 101, 9, 20, `TRW_TIME_MAX_US + 33'h0_0000_0001};

   trw_host u_host (.mclk_in(mclk_in), .stb_out(stb), .val_out(val));
   trw_gen u_trw_gen (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sel_wr_in(stb[0]),
      .sel_val_in(val[1:0]), .idx_wr_in(stb[1]), .idx_val_in(val[2:0]), .lvl_wr_in(stb[2]),
      .lvl_val_in(val[7:0]), .time_wr_in(stb[3]), .time_val_in(val), .run_in(stb[4]),
      .stop_in(stb[5]), .trig_in(stb[6]), .err_clr_in(err_clr_in), .dev_err_in(dev_err_in),
      .volt_static_in(volt_static_in), .curr_static_in(curr_static_in),
      .volt_set_out(volt_set_out), .curr_set_out(curr_set_out), .sel_out(sel_out),
      .idx_out(idx_out), .running_out(running_out), .cfg_done_out(cfg_done_out),
      .err_out(err_out), .seg_out(seg_out));

   // ==========================================================
   // Clock, watchdog and helpers
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // Longest run is a few wave periods of at most 9600 cycles each
   initial begin
      #(80000 * 25);
      n_errors++;
      complete_run;
   end
   task wait_cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task chk(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task pulse_clr;
      @(posedge mclk_in);
      err_clr_in <= 1'b1;
      @(posedge mclk_in);
      err_clr_in <= 1'b0;
      wait_cyc(2);
      chk(err_out, 0);
   endtask
   // Five segment changes; durations and levels from the staged set
   task period(input bit cur);
      int k;
      int c;
      int p;
      p = seg_out;
      for (k = 0; k < 5; k++) begin
         c = 0;
         while (seg_out === p[1:0] && c < 6000) begin
            wait_cyc(1);
            c++;
         end
         chk(cur ? curr_set_out : volt_set_out, (seg_out == 1 || seg_out == 2) ? hi : lo);
         chk(cur ? volt_set_out : curr_set_out, cur ? volt_static_in : curr_static_in);
         if (k > 0) chk(seg_out, (p + 1) % 4);
         if (k > 0) chk(c, (t[p] + 5) / 10 * 400);
         p = seg_out;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      rst_n_in = 1'b0;
      err_clr_in = 1'b0;
      dev_err_in = 1'b0;
      void'($urandom(32'h791a_516a));
      volt_static_in = 7'($urandom_range(100));
      curr_static_in = 7'($urandom_range(100));
      wait_cyc(11);
      chk({running_out, err_out, cfg_done_out, sel_out, volt_set_out}, 0);
      @(posedge mclk_in);
      rst_n_in <= 1'b1;
      u_host.cmd(4, 0);
      wait_cyc(3);
      chk({running_out, err_out}, 1);
      $display("test empty set done");
      u_host.cmd(0, `TRW_SEL_VOLT);
      for (i = 0; i < 5; i++) begin
         pulse_clr;
         u_host.cmd(1, bad_i[i]);
         u_host.cmd(bad_k[i], bad_v[i]);
         wait_cyc(3);
         chk(err_out, 1);
         chk(idx_out, bad_i[i]);
      end
      chk({cfg_done_out, sel_out}, 1);
      $display("test refusals done");
      lo = $urandom_range(49);
      hi = 50 + $urandom_range(50);
      foreach (t[j]) t[j] = 10 + $urandom_range(50);
      u_host.cfg(`TRW_SEL_VOLT, lo, hi, t);
      wait_cyc(3);
      chk(cfg_done_out, 1);
      u_host.cmd(4, 0);
      wait_cyc(3);
      chk(running_out, 1);
      period(0);
      $display("test voltage wave done");
      // Inverted set on current, staged while running, then swapped in
      lo = 60 + $urandom_range(40);
      hi = $urandom_range(50);
      foreach (t[j]) t[j] = 10 + $urandom_range(50);
      u_host.cfg(`TRW_SEL_CURR, lo, hi, t);
      while (seg_out !== 2'h3) wait_cyc(1);
      u_host.cmd(6, 0);
      wait_cyc(2);
      period(1);
      $display("test trigger done");
      u_host.cmd(5, 0);
      wait_cyc(3);
      chk({running_out, curr_set_out}, {1'b0, curr_static_in});
      pulse_clr;
      u_host.cmd(1, 0);
      u_host.cmd(3, `TRW_TIME_MAX_US);
      wait_cyc(3);
      chk(err_out, 1);
      u_host.cmd(4, 0);
      pulse_clr;
      @(posedge mclk_in);
      dev_err_in <= 1'b1;
      wait_cyc(8);
      chk({running_out, err_out}, 1);
      $display("test stop and halt done");
      complete_run;
   end
endmodule

bind trw_gen trw_gen_monitor u_mon (.mclk_in, .rst_n_in, .sel_wr_in, .sel_val_in, .lvl_wr_in,
   .lvl_val_in, .time_wr_in, .time_val_in, .run_in, .stop_in, .dev_err_in, .volt_static_in,
   .volt_set_out, .sel_out, .running_out, .cfg_done_out, .err_out, .seg_out);

// *** bench/trw_gen_monitor.sv ***
// Port checker of the ramp wave generator
`timescale 1ns/100ps
module trw_gen_monitor (
   input wire        mclk_in,
   input wire        rst_n_in,
   input wire        sel_wr_in,
   input wire [1:0]  sel_val_in,
   input wire        lvl_wr_in,
   input wire [7:0]  lvl_val_in,
   input wire        time_wr_in,
   input wire [32:0] time_val_in,
   input wire        run_in,
   input wire        stop_in,
   input wire        dev_err_in,
   input wire [6:0]  volt_static_in,
   input wire [6:0]  volt_set_out,
   input wire [1:0]  sel_out,
   input wire        running_out,
   input wire        cfg_done_out,
   input wire        err_out,
   input wire [1:0]  seg_out
);
   // ==========================================================
   // Assertions, one clock domain
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_lvl_range: assert property (lvl_wr_in && lvl_val_in > 8'h64 |-> ##[1:2] err_out)
      else $error("level above full scale not flagged");
   a_time_range: assert property (time_wr_in && (time_val_in < 33'h0_0000_000A ||
      time_val_in > 33'h1_65A0_BC00) |-> ##[1:2] err_out)
      else $error("time outside range not flagged");
   a_sel_hold: assert property (sel_wr_in |-> ##2 sel_out == $past(sel_val_in, 2))
      else $error("assignment readback wrong");
   a_stop_halts: assert property (stop_in |-> ##2 !running_out)
      else $error("stop did not halt");
   a_run_empty: assert property (run_in && !cfg_done_out |-> ##[1:2] err_out)
      else $error("run with empty set not flagged");
   // Registered path, so compare with the static input one edge back
   a_static_hold: assert property (!running_out && !$past(running_out) && $past(rst_n_in)
      |-> volt_set_out == $past(volt_static_in))
      else $error("idle set value not static");
   a_dev_err: assert property (dev_err_in |-> ##[1:5] (!running_out && err_out))
      else $error("device error did not halt");
   a_seg_order: assert property (running_out && $past(running_out) &&
      seg_out != $past(seg_out) |-> seg_out == $past(seg_out) + 2'h1 || seg_out == 2'h0)
      else $error("segment order broken");
endmodule

// *** bench/trw_host.sv ***
// Host model: command strobes toward the wave generator
`timescale 1ns/100ps
module trw_host (
   input  wire        mclk_in,
   output reg  [6:0]  stb_out,
   output reg  [32:0] val_out
);
   // Strobes: 0 sel, 1 index, 2 level, 3 time, 4 run, 5 stop, 6 trigger
   initial begin
      stb_out = 7'h00;
      val_out = 33'h0_0000_0000;
   end
   // Held through the sampling edge, then a free edge before the next one
   task cmd(input int k, input logic [32:0] v);
      begin
         @(posedge mclk_in);
         stb_out[k] <= 1'b1;
         val_out    <= v;
         @(posedge mclk_in);
         stb_out[k] <= 1'b0;
      end
   endtask
   // Assignment first, each index ahead of the value it steers
   task cfg(input int s, input int lo, input int hi, input int t[4]);
      int i;
      int k;
      begin
         cmd(0, s);
         for (i = 0; i < 4; i++) begin
            k = (i * 3 + 2) % 4;
            cmd(1, k);
            if (k < 2) cmd(2, k ? hi : lo);
            cmd(3, t[k]);
         end
      end
   endtask
endmodule

// *** core/trw_defs.vh ***
// Constants for the trapezoid ramp wave generator
`ifndef TRW_DEFS_VH
`define TRW_DEFS_VH

// Clock and step timing
`define TRW_MCLK_MHZ      40
`define TRW_STEP_US       10
`define TRW_STEP_CYC      (`TRW_MCLK_MHZ * `TRW_STEP_US)
`define TRW_HALF_STEP_US  34'h0_0000_0005
`define TRW_STEP_LAST     9'h18F

// Accepted ranges; time max is 6,000,000,000 us, total is 100 minutes in steps
`define TRW_LEVEL_MAX     8'h64
`define TRW_TIME_MIN_US   33'h0_0000_000A
`define TRW_TIME_MAX_US   33'h1_65A0_BC00
`define TRW_TOTAL_MAX     32'h23C3_4600

// Assignment codes
`define TRW_SEL_NONE      2'h0
`define TRW_SEL_VOLT      2'h1
`define TRW_SEL_CURR      2'h2

// Parameter indices, also the segment numbers in run order
`define TRW_IDX_RISE      3'h0
`define TRW_IDX_HIGH      3'h1
`define TRW_IDX_FALL      3'h2
`define TRW_IDX_LOW       3'h3

// Valid bit positions of the staged configuration
`define TRW_VB_LO         4
`define TRW_VB_HI         5
`define TRW_VB_ALL        6'h3F

`endif

// *** core/trw_gen.v ***
// Trapezoid ramp wave generator: staging, run control and ramp engine
`timescale 1ns/100ps
`include "trw_defs.vh"

module trw_gen (
   input  wire        mclk_in,
   input  wire        rst_n_in,
   input  wire        sel_wr_in,
   input  wire [1:0]  sel_val_in,
   input  wire        idx_wr_in,
   input  wire [2:0]  idx_val_in,
   input  wire        lvl_wr_in,
   input  wire [7:0]  lvl_val_in,
   input  wire        time_wr_in,
   input  wire [32:0] time_val_in,
   input  wire        run_in,
   input  wire        stop_in,
   input  wire        trig_in,
   input  wire        err_clr_in,
   input  wire        dev_err_in,
   input  wire [6:0]  volt_static_in,
   input  wire [6:0]  curr_static_in,
   output reg  [6:0]  volt_set_out,
   output reg  [6:0]  curr_set_out,
   output reg  [1:0]  sel_out,
   output reg  [2:0]  idx_out,
   output reg         running_out,
   output reg         cfg_done_out,
   output reg         err_out,
   output reg  [1:0]  seg_out
);

   // ==========================================================
   // Overview
   // Host side: every command arrives as a one-clock strobe with its value.
   // The assignment and the parameter index are plain registers; a level or
   // time write lands in the staged set at the slot the index names.
   // Only a run, or a trigger while running, copies the staged set into the
   // active set, so a host may rewrite any parameter mid-wave without a glitch.
   //
   // Write checks all happen in the strobe cycle, the range checks against the raw
   // value and the span check against the rounded one, so a refused write never
   // touches the staged set and the error flag is sticky until cleared; a fresh
   // error in the clearing cycle wins.
   //
   // The wave engine counts 10 us steps from a divider that restarts on every
   // load, so the first segment after run or trigger is its full length plus one clock.
   // Levels move one percent at a time; the accumulator spreads the units of a
   // ramp evenly over its steps and the segment end snaps to the target level.
   //
   // Limitation: output resolution is one percent of rating, so a slow ramp
   // over a small span is a staircase rather than a smooth slope.
   // Limitation: the total-time check uses the staged times only; a write that
   // would overflow the span is refused even if the host meant to shrink
   // another segment next, so shrink first and grow second.
   //
   // Index values 4 to 7 are stored and echoed but steer no slot; level and
   // time writes under them are refused.
   //
   // Stop and a synchronised device error outrank run and trigger in the same
   // cycle; a device error held high keeps the generator parked.

   // ==========================================================
   // Declarations
   reg  [1:0]   sel_r;
   reg  [2:0]   idx_r;
   reg  [6:0]   stg_lo_r;
   reg  [6:0]   stg_hi_r;
   reg  [5:0]   stg_vld_r;
   reg  [1:0]   act_sel_r;
   reg  [6:0]   act_lo_r;
   reg  [6:0]   act_hi_r;
   reg  [29:0]  stg_t_r [0:3];
   reg  [29:0]  act_t_r [0:3];
   reg          run_r;
   reg  [1:0]   seg_r;
   reg  [29:0]  seg_cnt_r;
   reg  [30:0]  acc_r;
   reg  [6:0]   cur_r;
   reg  [8:0]   div_r;
   reg          tick_r;
   reg          derr_s1_r;
   reg          derr_s2_r;
   reg          err_r;
   wire [33:0]  time_rnd;
   wire [33:0]  time_rnd_div;
   wire [29:0]  time_q;
   wire         time_in_rng;
   wire         idx_ok;
   wire         load;
   wire         start;
   wire         halt;
   reg  [31:0]  sum_nxt;
   reg          time_ok;
   reg          lvl_ok;
   reg          bad_wr;
   reg          bad_cmd;
   reg  [29:0]  dur;
   reg  [6:0]   to_lvl;
   reg          dir_up;
   reg  [6:0]   diff;
   wire         ramp;
   integer      k;

   // ==========================================================
   // Device error input from outside the clock domain
   // Two stages guard against metastability; only the second stage is read
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         derr_s1_r <= 1'b0;
         derr_s2_r <= 1'b0;
      end else begin
         derr_s1_r <= dev_err_in;
         derr_s2_r <= derr_s1_r;
      end
   end

   // ==========================================================
   // Selection and index registers
   // Assignment is kept as written so a read-back shows the last choice
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_r <= `TRW_SEL_NONE;
         idx_r <= `TRW_IDX_RISE;
      end else begin
         if (sel_wr_in)
            sel_r <= sel_val_in;
         if (idx_wr_in)
            idx_r <= idx_val_in;
      end
   end

   // ==========================================================
   // Time quantisation: round to nearest 10 us step
   // A constant divide keeps the path short enough at 40 MHz
   // The largest raw value, over 8.5e9 us, still yields fewer than 2^30 steps,
   // so the quotient fits the 30-bit time registers without saturation.
   assign time_rnd     = {1'b0, time_val_in} + `TRW_HALF_STEP_US;
   assign time_rnd_div = time_rnd / 34'h0_0000_000A;
   assign time_q       = time_rnd_div[29:0];
   assign time_in_rng = (time_val_in >= `TRW_TIME_MIN_US) &&
                        (time_val_in <= `TRW_TIME_MAX_US);
   assign idx_ok      = (idx_r <= `TRW_IDX_LOW);

   // ==========================================================
   // Write checks: level range, index, time range and total span
   always @* begin
      sum_nxt = 32'h0000_0000;
      for (k = 0; k < 4; k = k + 1) begin
         if (idx_r[1:0] == k[1:0])
            sum_nxt = sum_nxt + {2'h0, time_q};
         else
            sum_nxt = sum_nxt + {2'h0, stg_t_r[k]};
      end
      time_ok = time_in_rng && idx_ok && (sum_nxt <= `TRW_TOTAL_MAX);
      lvl_ok  = (lvl_val_in <= `TRW_LEVEL_MAX) &&
                ((idx_r == `TRW_IDX_RISE) || (idx_r == `TRW_IDX_HIGH));
      bad_wr  = (lvl_wr_in && !lvl_ok) || (time_wr_in && !time_ok);
   end

   // ==========================================================
   // Staged levels and valid bits
   // Reset empties the configuration; nothing survives a power cycle
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stg_lo_r  <= 7'h00;
         stg_hi_r  <= 7'h00;
         stg_vld_r <= 6'h00;
      end else begin
         if (lvl_wr_in && lvl_ok) begin
            if (idx_r == `TRW_IDX_RISE) begin
               stg_lo_r               <= lvl_val_in[6:0];
               stg_vld_r[`TRW_VB_LO]  <= 1'b1;
            end else begin
               stg_hi_r               <= lvl_val_in[6:0];
               stg_vld_r[`TRW_VB_HI]  <= 1'b1;
            end
         end
         if (time_wr_in && time_ok)
            stg_vld_r[idx_r[1:0]] <= 1'b1;
      end
   end

   // ==========================================================
   // Per-segment time: staged copy and active copy
   // Background writes touch only the staged copy, so a running wave is undisturbed
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : seg_time
         always @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               stg_t_r[g] <= 30'h0000_0000;
               act_t_r[g] <= 30'h0000_0000;
            end else begin
               if (time_wr_in && time_ok && (idx_r[1:0] == g))
                  stg_t_r[g] <= time_q;
               if (load)
                  act_t_r[g] <= stg_t_r[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Run control
   // Stop beats trigger and run; run or trigger on an incomplete set is refused
   assign halt  = stop_in || derr_s2_r;
   assign load  = !halt && (run_in || (trig_in && run_r)) &&
                  (stg_vld_r == `TRW_VB_ALL);
   assign start = load;

   // A trigger while stopped is quietly ignored when the set is complete;
   // with an incomplete set it is flagged like a refused run.
   always @* begin
      bad_cmd = !halt && (run_in || trig_in) && (stg_vld_r != `TRW_VB_ALL);
   end

   // Active levels and assignment follow the staged set on every load
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         act_sel_r <= `TRW_SEL_NONE;
         act_lo_r  <= 7'h00;
         act_hi_r  <= 7'h00;
      end else if (load) begin
         act_sel_r <= sel_r;
         act_lo_r  <= stg_lo_r;
         act_hi_r  <= stg_hi_r;
      end
   end

   // Sticky error flag: a new error in the clearing cycle wins
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         err_r <= 1'b0;
      else if (bad_wr || bad_cmd || derr_s2_r)
         err_r <= 1'b1;
      else if (err_clr_in)
         err_r <= 1'b0;
   end

   // ==========================================================
   // 10 us step enable
   // Held clear while stopped so the count is clean at the next start
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_r  <= 9'h000;
         tick_r <= 1'b0;
      end else if (start || !run_r) begin
         div_r  <= 9'h000;
         tick_r <= 1'b0;
      end else if (div_r == `TRW_STEP_LAST) begin
         div_r  <= 9'h000;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 9'h001;
         tick_r <= 1'b0;
      end
   end

   // ==========================================================
   // Current segment: duration, end level and slope direction
   // Segment order matches index order: rise, high dwell, fall, low dwell
   // Ramp segments are even numbered; dwells hold the level
   assign ramp = ~seg_r[0];
   always @* begin
      dur    = act_t_r[seg_r];
      to_lvl = (seg_r == 2'h0 || seg_r == 2'h1) ? act_hi_r : act_lo_r;
      dir_up = (seg_r == 2'h0) ? (act_hi_r >= act_lo_r) :
                                 (act_lo_r >= act_hi_r);
      diff   = (act_hi_r >= act_lo_r) ? (act_hi_r - act_lo_r) :
                                        (act_lo_r - act_hi_r);
   end

   // ==========================================================
   // Ramp engine
   // Each step adds the level span to an accumulator; between steps one unit of
   // level is issued per clock while the accumulator holds a whole duration.
   // At most 100 units per step fit easily in the 400 clocks of a step.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_r     <= 1'b0;
         seg_r     <= 2'h0;
         seg_cnt_r <= 30'h0000_0000;
         acc_r     <= 31'h0000_0000;
         cur_r     <= 7'h00;
      end else if (halt) begin
         run_r     <= 1'b0;
      end else if (start) begin
         run_r     <= 1'b1;
         seg_r     <= 2'h0;
         seg_cnt_r <= 30'h0000_0000;
         acc_r     <= 31'h0000_0000;
         cur_r     <= stg_lo_r;
      end else if (run_r && tick_r) begin
         if (seg_cnt_r + 30'h0000_0001 >= dur) begin
            seg_r     <= seg_r + 2'h1;
            seg_cnt_r <= 30'h0000_0000;
            acc_r     <= 31'h0000_0000;
            cur_r     <= to_lvl;
         end else begin
            seg_cnt_r <= seg_cnt_r + 30'h0000_0001;
            if (ramp)
               acc_r <= acc_r + {24'h00_0000, diff};
         end
      end else if (run_r && ramp && (acc_r >= {1'b0, dur}) && (cur_r != to_lvl)) begin
         acc_r <= acc_r - {1'b0, dur};
         if (dir_up)
            cur_r <= cur_r + 7'h01;
         else
            cur_r <= cur_r - 7'h01;
      end
   end

   // ==========================================================
   // Registered outputs
   // The quantity not assigned, and both while stopped, follow the static set values
   // idx_out and sel_out echo the host registers one clock late so a read-back
   // never races the write that changed them
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         volt_set_out <= 7'h00;
         curr_set_out <= 7'h00;
         sel_out      <= `TRW_SEL_NONE;
         idx_out      <= `TRW_IDX_RISE;
         running_out  <= 1'b0;
         cfg_done_out <= 1'b0;
         err_out      <= 1'b0;
         seg_out      <= 2'h0;
      end else begin
         volt_set_out <= (run_r && act_sel_r == `TRW_SEL_VOLT) ? cur_r :
                         volt_static_in;
         curr_set_out <= (run_r && act_sel_r == `TRW_SEL_CURR) ? cur_r :
                         curr_static_in;
         sel_out      <= sel_r;
         idx_out      <= idx_r;
         running_out  <= run_r;
         cfg_done_out <= (stg_vld_r == `TRW_VB_ALL);
         err_out      <= err_r;
         seg_out      <= seg_r;
      end
   end

endmodule
